// [dv/nio_pins_model.sv]
`timescale 1ns/1ps
// released lines follow the outside circuit, which has its own pull resistor
module nio_pins_model(
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_i);
endmodule

// [dv/nio_port_checker.sv]
`timescale 1ns/1ps
module nio_port_checker(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic stop_mode_recovery_i,
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_wdata_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic [1:0] mode_rdata_o,
  input wire logic [7:0] config_rdata_o,
  input wire logic [7:0] port_zero_lines_o,
  input wire logic [7:0] port_zero_lines_oe_n_o,
  input wire logic [7:0] pullup_en_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_reset_inputs: assert property (disable iff (1'b0) sys_rst_i |=> mode_rdata_o == 2'h3) else $error("dir");
  chk_recovery_inputs: assert property (stop_mode_recovery_i |=> mode_rdata_o == 2'h3) else $error("recovery");
  chk_mode_load: assert property (mode_wr_i && !stop_mode_recovery_i |=> mode_rdata_o == $past(mode_wdata_i))
    else $error("mode");
  chk_pullup_off: assert property (pullup_en_o == {{4{mode_rdata_o[1]}}, {4{mode_rdata_o[0]}}}) else $error("pu");
  chk_input_float: assert property ((port_zero_lines_oe_n_o & pullup_en_o) == pullup_en_o) else $error("oe");
  chk_drain_zero: assert property (!config_rdata_o[2] |-> (~port_zero_lines_oe_n_o & port_zero_lines_o) == 8'h00)
    else $error("od");
  chk_latch_load: assert property (data_wr_i |=> port_zero_lines_o == $past(data_wdata_i)) else $error("lat");
endmodule
bind nio_port nio_port_checker chk(
  .clock_i(clock_i),
  .sys_rst_i(sys_rst_i),
  .stop_mode_recovery_i(stop_mode_recovery_i),
  .mode_wr_i(mode_wr_i),
  .mode_wdata_i(mode_wdata_i),
  .data_wr_i(data_wr_i),
  .data_wdata_i(data_wdata_i),
  .mode_rdata_o(mode_rdata_o),
  .config_rdata_o(config_rdata_o),
  .port_zero_lines_o(port_zero_lines_o),
  .port_zero_lines_oe_n_o(port_zero_lines_oe_n_o),
  .pullup_en_o(pullup_en_o)
);

// [dv/test_nio_port.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module test_nio_port;
  logic clock_i = 0, sys_rst_i = 1, recov = 0, mw = 0, cw = 0, dw = 0;
  logic [1:0] md = 2'h3, mq;
  logic [7:0] cd = 8'h00, dd = 8'h00, ext = 8'h3C, pin, q, cfg, lat, oen, pu;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #12.5 clock_i = ~clock_i;
  nio_port DUT(.clock_i, .sys_rst_i, .stop_mode_recovery_i(recov), .mode_wr_i(mw), .mode_wdata_i(md),
    .config_wr_i(cw), .config_wdata_i(cd), .data_wr_i(dw), .data_wdata_i(dd), .data_rdata_o(q),
    .mode_rdata_o(mq), .config_rdata_o(cfg), .port_zero_lines_i(pin), .port_zero_lines_o(lat),
    .port_zero_lines_oe_n_o(oen), .pullup_en_o(pu));
  nio_pins_model ext_pins(.oe_n_i(oen), .out_i(lat), .ext_i(ext), .pin_o(pin));
  task automatic put(input logic [1:0] m, input logic [7:0] c, input logic [7:0] d);
    @(posedge clock_i);
    mw <= 1'h1;
    cw <= 1'h1;
    dw <= 1'h1;
    md <= m;
    cd <= c;
    dd <= d;
    @(posedge clock_i);
    mw <= 1'h0;
    cw <= 1'h0;
    dw <= 1'h0;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic t_reset;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    `CHK("mode", 2'h3, mq)
    `CHK("oe", 8'hFF, oen)
    `CHK("pullup", 8'hFF, pu)
    `CHK("config", 8'h00, cfg)
    `CHK("read", ext, q)
  endtask
  task automatic t_push;
    put(2'h2, 8'h04, 8'hA5);
    `CHK("mode", 2'h2, mq)
    `CHK("config", 8'h04, cfg)
    `CHK("latch", 8'hA5, lat)
    `CHK("pullup", 8'hF0, pu)
    `CHK("oe", 8'hF0, oen)
    `CHK("read", 8'h35, q)
  endtask
  // input nibble follows its pins; a one-cycle pulse must not reach the read data
  task automatic t_pins;
    @(posedge clock_i);
    ext <= 8'hC3;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    `CHK("read", 8'hC5, q)
    @(posedge clock_i);
    ext <= 8'h33;
    @(posedge clock_i);
    ext <= 8'hC3;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    `CHK("glitch", 8'hC5, q)
  endtask
  task automatic t_drain;
    put(2'h0, 8'h00, 8'hA5);
    `CHK("oe", 8'hA5, oen)
    `CHK("pin", 8'h81, pin)
    `CHK("pullup", 8'h00, pu)
    `CHK("read", 8'hA5, q)
  endtask
  // a mode write in the recovery cycle must lose
  task automatic t_recovery;
    @(posedge clock_i);
    recov <= 1'h1;
    mw <= 1'h1;
    md <= 2'h0;
    @(posedge clock_i);
    recov <= 1'h0;
    mw <= 1'h0;
    @(negedge clock_i);
    `CHK("mode", 2'h3, mq)
    `CHK("oe", 8'hFF, oen)
    `CHK("pullup", 8'hFF, pu)
  endtask
  task automatic t_midreset;
    put(2'h0, 8'h04, 8'h5A);
    `CHK("oe", 8'h00, oen)
    `CHK("pin", 8'h5A, pin)
    @(posedge clock_i);
    sys_rst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    @(negedge clock_i);
    `CHK("mode", 2'h3, mq)
    `CHK("config", 8'h00, cfg)
    `CHK("latch", 8'h00, lat)
    `CHK("oe", 8'hFF, oen)
    `CHK("pullup", 8'hFF, pu)
  endtask
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 500)
    begin
      fail_count++;
      final_report;
    end
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 0;
    t_reset;
    t_push;
    t_pins;
    t_drain;
    t_recovery;
    t_midreset;
    final_report;
  end
endmodule

// [logic/nio_cfg.svh]
`ifndef NIO_CFG_SVH
`define NIO_CFG_SVH
`define NIO_WIDTH 8
`define NIO_NIBBLES 2
`define NIO_NIBBLE_W 4
`define NIO_DIR_RESET 2'h3
`define NIO_DRIVE_BIT 2
`define NIO_OUT_RESET 8'h00
`define NIO_CFG_RESET 8'h00
`define NIO_PIN_RESET 8'h00
`define NIO_OE_RESET 8'hFF
`define NIO_PULLUP_RESET 8'hFF
`define NIO_SYNC_STAGES 3
`endif

// [logic/nio_pin_sync.sv]
`timescale 1ns/1ps
`include "nio_cfg.svh"
module nio_pin_sync
  import nio_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  nio_sync_if.dst sync
);
  nio_byte_t s1_q;
  nio_byte_t s2_q;
  nio_byte_t s3_q;
  nio_byte_t clean_q;
  nio_byte_t agree;

  // a bit changes only when the last two stages agree
  genvar g;
  generate
    for (g = 0; g < `NIO_WIDTH; g = g + 1)
    begin : g_bit
      assign agree[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : clean_q[g];
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= `NIO_PIN_RESET;
      s2_q <= `NIO_PIN_RESET;
      s3_q <= `NIO_PIN_RESET;
      clean_q <= `NIO_PIN_RESET;
    end
    else
    begin
      s1_q <= sync.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= agree;
    end
  end

  assign sync.clean = clean_q;
endmodule

// [logic/nio_pkg.sv]
package nio_pkg;
  typedef logic [7:0] nio_byte_t;
  typedef logic [1:0] nio_dir_t;
  typedef enum logic [1:0] {
    NIO_DRV_PUSH_PULL = 2'h1,
    NIO_DRV_OPEN_DRAIN = 2'h2
  } nio_drive_e;
endpackage

// [logic/nio_port.sv]
// Behaviour
// - eight lines, each an input or an output by its direction
// - direction chosen per nibble: low four lines and high four lines
// - all drivers push-pull or open-drain from the drive type select bit
// - hardware reset puts both nibbles into input
// - pull-up disabled on every line programmed as output
// - stop mode recovery restores input direction like reset
`timescale 1ns/1ps
`include "nio_cfg.svh"
module nio_port
  import nio_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic stop_mode_recovery_i,
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_wdata_i,
  input wire logic config_wr_i,
  input wire logic [7:0] config_wdata_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] data_rdata_o,
  output logic [1:0] mode_rdata_o,
  output logic [7:0] config_rdata_o,
  input wire logic [7:0] port_zero_lines_i,
  output logic [7:0] port_zero_lines_o,
  output logic [7:0] port_zero_lines_oe_n_o,
  output logic [7:0] pullup_en_o
);
  // a set mode bit means that nibble is an input (bit0 low nibble, bit1 high nibble)
  nio_dir_t dir_in_q;
  nio_dir_t dir_in_d;
  nio_byte_t out_q;
  nio_byte_t out_d;
  nio_byte_t cfg_q;
  nio_byte_t cfg_d;
  nio_byte_t rd_q;
  nio_byte_t rd_d;

  // pad controls, kept in flops of their own
  nio_byte_t oe_n_q;
  nio_byte_t oe_n_d;
  nio_byte_t pullup_q;
  nio_byte_t pullup_d;

  // decoded strobes and per-nibble, per-line selects
  logic dir_force;
  logic dir_load;
  logic cfg_load;
  logic out_load;
  logic next_push_pull;
  nio_drive_e drive_d;
  nio_dir_t nibble_is_out;
  nio_dir_t next_nibble_out;
  nio_byte_t line_is_out;
  nio_byte_t next_is_out;
  nio_byte_t next_drives;
  nio_byte_t pin_clean;

  // pins are asynchronous, so they reach the logic only through the filter
  nio_sync_if sync ();
  assign sync.raw = port_zero_lines_i;
  nio_pin_sync u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .sync(sync)
  );
  assign pin_clean = sync.clean;

  // strobes are decoded once so each register process only takes a next value
  assign dir_force = stop_mode_recovery_i;
  assign dir_load = mode_wr_i & ~stop_mode_recovery_i;
  assign cfg_load = config_wr_i;
  assign out_load = data_wr_i;

  // recovery wins over a same-cycle mode write so the port always wakes as input
  assign dir_in_d = dir_force ? `NIO_DIR_RESET :
                    dir_load ? mode_wdata_i : dir_in_q;
  // only the drive type select bit acts; the other bits read back as written
  assign cfg_d = cfg_load ? config_wdata_i : cfg_q;
  // a latch write on an input nibble is kept and drives once that nibble turns output
  assign out_d = out_load ? data_wdata_i : out_q;

  // pad controls come from next values, so they move on the same edge as the registers
  assign drive_d = cfg_d[`NIO_DRIVE_BIT] ? NIO_DRV_PUSH_PULL : NIO_DRV_OPEN_DRAIN;
  assign next_push_pull = (drive_d == NIO_DRV_PUSH_PULL);

  genvar n;
  generate
    for (n = 0; n < `NIO_NIBBLES; n = n + 1)
    begin : g_nibble
      assign nibble_is_out[n] = ~dir_in_q[n];
      assign next_nibble_out[n] = ~dir_in_d[n];
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < `NIO_WIDTH; g = g + 1)
    begin : g_line
      assign line_is_out[g] = nibble_is_out[g / `NIO_NIBBLE_W];
      assign next_is_out[g] = next_nibble_out[g / `NIO_NIBBLE_W];
      // open drain only pulls low; a high latch releases the line
      assign next_drives[g] = next_push_pull | ~out_d[g];
      assign oe_n_d[g] = ~(next_is_out[g] & next_drives[g]);
      // the pull-up is off on an output line even where the option is fitted
      assign pullup_d[g] = ~next_is_out[g];
      assign rd_d[g] = line_is_out[g] ? out_q[g] : pin_clean[g];
    end
  endgenerate

  // reset and recovery both leave this at all inputs
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      dir_in_q <= `NIO_DIR_RESET;
    end
    else
    begin
      dir_in_q <= dir_in_d;
    end
  end

  // the latch keeps its value across direction changes
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      out_q <= `NIO_OUT_RESET;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  // reset selects open drain, so no line drives high until software asks
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      cfg_q <= `NIO_CFG_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  // read data is registered so one access sees one stable value
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rd_q <= `NIO_PIN_RESET;
    end
    else
    begin
      rd_q <= rd_d;
    end
  end

  // enable in a flop so the pad never sees a decode glitch
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      oe_n_q <= `NIO_OE_RESET;
    end
    else
    begin
      oe_n_q <= oe_n_d;
    end
  end

  // high means the pull-up may be switched on
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      pullup_q <= `NIO_PULLUP_RESET;
    end
    else
    begin
      pullup_q <= pullup_d;
    end
  end

  assign data_rdata_o = rd_q;
  assign mode_rdata_o = dir_in_q;
  assign config_rdata_o = cfg_q;
  assign port_zero_lines_o = out_q;
  assign port_zero_lines_oe_n_o = oe_n_q;
  assign pullup_en_o = pullup_q;
endmodule

// [logic/nio_sync_if.sv]
`timescale 1ns/1ps
interface nio_sync_if;
  logic [7:0] raw;
  logic [7:0] clean;
  modport src (output raw, input clean);
  modport dst (input raw, output clean);
endinterface
